// [src/pdcs_pkg.sv]
// Constants for the port device control and status register pair
`default_nettype none

package pdcs_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  DEV_CTLSTS_ADDR = 8'hc8;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Control half, bits 15:0
  // ---------------------------------------------------------------
  localparam int unsigned CTL_COR_EN    = 0;
  localparam int unsigned CTL_NF_EN     = 1;
  localparam int unsigned CTL_FAT_EN    = 2;
  localparam int unsigned CTL_UR_EN     = 3;
  localparam int unsigned CTL_RELAX     = 4;
  localparam int unsigned CTL_MPS_LSB   = 5;
  localparam int unsigned CTL_MPS_MSB   = 7;
  localparam int unsigned CTL_EXT_TAG   = 8;
  localparam int unsigned CTL_PHANTOM   = 9;
  localparam int unsigned CTL_AUX_PM    = 10;
  localparam int unsigned CTL_NO_SNOOP  = 11;
  localparam int unsigned CTL_MRRS_LSB  = 12;
  localparam int unsigned CTL_MRRS_MSB  = 14;
  localparam int unsigned CTL_RSVD      = 15;

  // ---------------------------------------------------------------
  // Status half, bits 31:16
  // ---------------------------------------------------------------
  localparam int unsigned STS_ERR_LSB   = 16;
  localparam int unsigned STS_AUX_DET   = 20;
  localparam int unsigned STS_TRANS_PND = 21;
  localparam int unsigned STS_RSVD_LSB  = 22;
  localparam int unsigned STS_RSVD_MSB  = 31;
  localparam int unsigned NUM_ERR       = 4;

  // ---------------------------------------------------------------
  // Byte lanes and reset values
  // ---------------------------------------------------------------
  localparam int unsigned BE_CTL_LO     = 0;
  localparam int unsigned BE_CTL_HI     = 1;
  localparam int unsigned BE_STS_LO     = 2;
  localparam logic [3:0]  RPT_EN_RST    = 4'h0;
  localparam logic [3:0]  ERR_FLAG_RST  = 4'h0;
  localparam logic        AUX_DET_RST   = 1'b1;
  localparam logic        AUX_PM_RST    = 1'b0;

  // ---------------------------------------------------------------
  // Payload size codes
  // ---------------------------------------------------------------
  localparam logic [2:0]  MPS_128       = 3'h0;
  localparam logic [2:0]  MPS_256       = 3'h1;
  localparam logic [2:0]  MPS_512       = 3'h2;
  localparam logic [2:0]  MPS_RST       = MPS_128;
  localparam logic [2:0]  MRRS_FIXED    = 3'h0;

endpackage

`default_nettype wire

// [src/pdcs_regs.sv]
// Port device control and status registers behind an Avalon-MM slave
//
// What this block does
// (RULE1) Bit 0 read-write correctable error reporting enable, resets to zero.
// (RULE2) Bit 1 read-write non-fatal error reporting enable, resets to zero.
// (RULE3) Bit 2 read-write fatal error reporting enable, resets to zero.
// (RULE4) Bit 3 read-write unsupported request reporting enable, resets to zero.
// (RULE5) Bit 4 relaxed ordering reads zero, writes ignored.
// (RULE6) Payload size bits 7:5 reset 000b, writable, clamped to supported maximum.
// (RULE7) Payload codes: 000b 128, 001b 256, 010b 512 bytes; others reserved.
// (RULE8) Supported maximum is 001b with strap low, 010b with strap high.
// (RULE9) Extended tag bit 8 and phantom bit 9 always read zero.
// (RULE10) Bit 10 read-write auxiliary power enable, resets to zero.
// (RULE11) Bit 11 no snoop always reads zero.
// (RULE12) Read request size bits 14:12 hardwired to 000b.
// (RULE13) Status bit 16 sets on correctable error, write one clears.
// (RULE14) Status bit 17 sets on non-fatal error, write one clears.
// (RULE15) Status bit 18 sets on fatal error, write one clears.
// (RULE16) Status bit 19 sets on unsupported request, write one clears.
// (RULE17) Detected flags set regardless of the reporting enables.
// (RULE18) Status bit 20 read-only auxiliary power detected, resets to one.
// (RULE19) Status bit 21 transactions pending hardwired to zero.
// (RULE20) Bit 15 and bits 31:22 read zero; writing zero leaves flags unchanged.
// (RULE21) Detection in the same cycle as a clear keeps the flag set.
//
// Design decision made here: the Avalon-MM slave port.
`default_nettype none

module pdcs_regs
  import pdcs_pkg::*;
#(
  parameter int unsigned P_ADDR_W = ADDR_W
) (
  input  wire logic                i_clk,
  input  wire logic                i_reset_n,
  input  wire logic [P_ADDR_W-1:0] i_avs_address,
  input  wire logic                i_avs_read,
  input  wire logic                i_avs_write,
  input  wire logic [31:0]         i_avs_writedata,
  input  wire logic [3:0]          i_avs_byteenable,
  output logic      [31:0]         o_avs_readdata,
  output logic                     o_avs_waitrequest,
  input  wire logic [NUM_ERR-1:0]  i_err_detect,
  input  wire logic                i_payload_512_strap,
  input  wire logic                i_aux_power_detect,
  output logic      [NUM_ERR-1:0]  o_report_enable,
  output logic      [NUM_ERR-1:0]  o_err_report,
  output logic      [2:0]          o_max_payload,
  output logic                     o_aux_pm_enable
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (P_ADDR_W < ADDR_W) begin : g_addr_chk
    $error("Address width too narrow for the register offset");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic               wait_reg;
  logic [31:0]        rdata_reg;
  logic [NUM_ERR-1:0] rpt_en_reg;
  logic [2:0]         mps_reg;
  logic [2:0]         mps_next;
  logic               aux_pm_reg;
  logic [NUM_ERR-1:0] err_flag_reg;
  logic [NUM_ERR-1:0] err_rpt_reg;
  logic               aux_det_reg;
  logic               strap_meta_reg;
  logic               strap_sync_reg;
  logic               aux_meta_reg;
  logic               aux_sync_reg;
  logic               req;
  logic               hit;
  logic               wr_hit;
  logic [NUM_ERR-1:0] w1c;
  logic [2:0]         mps_max;
  logic [2:0]         mps_wr;
  logic [15:0]        ctl_view;
  logic [15:0]        sts_view;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Strap and aux detect come from pins; two flops before use
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end else begin
      strap_meta_reg <= i_payload_512_strap;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Held at one through reset so the status bit never dips low
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      aux_meta_reg <= AUX_DET_RST;
      aux_sync_reg <= AUX_DET_RST;
    end else begin
      aux_meta_reg <= i_aux_power_detect;
      aux_sync_reg <= aux_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // One wait cycle, then a single ready cycle per request
  assign req    = i_avs_read || i_avs_write;
  assign hit    = (i_avs_address == P_ADDR_W'(DEV_CTLSTS_ADDR));
  assign wr_hit = i_avs_write && !wait_reg && hit;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wait_reg <= 1'b1;
    end else if (wait_reg && req) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Read views
  // ---------------------------------------------------------------
  always_comb begin
    ctl_view                           = 16'h0000;
    ctl_view[CTL_UR_EN:CTL_COR_EN]     = rpt_en_reg;        // RULE1
    ctl_view[CTL_RELAX]                = 1'b0;              // RULE5
    ctl_view[CTL_MPS_MSB:CTL_MPS_LSB]  = mps_reg;           // RULE6
    ctl_view[CTL_EXT_TAG]              = 1'b0;              // RULE9
    ctl_view[CTL_PHANTOM]              = 1'b0;              // RULE9
    ctl_view[CTL_AUX_PM]               = aux_pm_reg;        // RULE10
    ctl_view[CTL_NO_SNOOP]             = 1'b0;              // RULE11
    ctl_view[CTL_MRRS_MSB:CTL_MRRS_LSB] = MRRS_FIXED;      // RULE12
    ctl_view[CTL_RSVD]                 = 1'b0;              // RULE20
  end

  always_comb begin
    sts_view                                   = 16'h0000;
    sts_view[NUM_ERR-1:0]                      = err_flag_reg;  // RULE13 RULE14
    sts_view[STS_AUX_DET-STS_ERR_LSB]          = aux_det_reg;   // RULE18
    sts_view[STS_TRANS_PND-STS_ERR_LSB]        = 1'b0;          // RULE19
  end

  // Unmapped reads return zero and writes there are dropped
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rdata_reg <= UNMAPPED_DATA;
    end else if (wait_reg && i_avs_read && hit) begin
      rdata_reg <= {sts_view, ctl_view};                    // RULE20
    end else if (wait_reg && i_avs_read) begin
      rdata_reg <= UNMAPPED_DATA;
    end
  end

  // ---------------------------------------------------------------
  // Control half
  // ---------------------------------------------------------------
  assign mps_max = strap_sync_reg ? MPS_512 : MPS_256;      // RULE8
  assign mps_wr  = i_avs_writedata[CTL_MPS_MSB:CTL_MPS_LSB];

  // Reserved codes sit above the maximum, so they clamp too
  assign mps_next = (mps_wr > mps_max) ? mps_max : mps_wr;  // RULE7

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rpt_en_reg <= RPT_EN_RST;
    end else if (wr_hit && i_avs_byteenable[BE_CTL_LO]) begin
      rpt_en_reg <= i_avs_writedata[CTL_UR_EN:CTL_COR_EN];  // RULE2
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      mps_reg <= MPS_RST;
    end else if (wr_hit && i_avs_byteenable[BE_CTL_LO]) begin
      mps_reg <= mps_next;                                  // RULE6
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      aux_pm_reg <= AUX_PM_RST;
    end else if (wr_hit && i_avs_byteenable[BE_CTL_HI]) begin
      aux_pm_reg <= i_avs_writedata[CTL_AUX_PM];            // RULE10
    end
  end

  // ---------------------------------------------------------------
  // Status half
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      aux_det_reg <= AUX_DET_RST;
    end else begin
      aux_det_reg <= aux_sync_reg;                          // RULE18
    end
  end

  // Per-flag set wins over clear so no event is lost
  for (genvar g = 0; g < NUM_ERR; g++) begin : g_err
    assign w1c[g] = wr_hit && i_avs_byteenable[BE_STS_LO]
                    && i_avs_writedata[STS_ERR_LSB+g];      // RULE20

    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        err_flag_reg[g] <= ERR_FLAG_RST[g];
      end else begin
        err_flag_reg[g] <= i_err_detect[g] | (err_flag_reg[g] & ~w1c[g]); // RULE21
      end
    end

    // Reporting is gated; logging is not
    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        err_rpt_reg[g] <= 1'b0;
      end else begin
        err_rpt_reg[g] <= i_err_detect[g] & rpt_en_reg[g];  // RULE3
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_avs_waitrequest = wait_reg;
  assign o_avs_readdata    = rdata_reg;
  assign o_report_enable   = rpt_en_reg;                    // RULE4
  assign o_err_report      = err_rpt_reg;
  assign o_max_payload     = mps_reg;
  assign o_aux_pm_enable   = aux_pm_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  property p_ready_one;
    req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_ready_one: assert property (p_ready_one) // Avalon-MM slave port design decision
    else $error("Ready pulse not exactly one cycle after request");

  property p_relax_zero;
    !o_avs_waitrequest |-> o_avs_readdata[CTL_RELAX] == 1'b0;
  endproperty
  a_relax_zero: assert property (p_relax_zero) // RULE5
    else $error("Relaxed ordering bit read nonzero");

  property p_tag_zero;
    !o_avs_waitrequest |-> o_avs_readdata[CTL_PHANTOM:CTL_EXT_TAG] == 2'b00;
  endproperty
  a_tag_zero: assert property (p_tag_zero) // RULE9
    else $error("Extended tag or phantom bit read nonzero");

  property p_snoop_zero;
    !o_avs_waitrequest |-> o_avs_readdata[CTL_NO_SNOOP] == 1'b0;
  endproperty
  a_snoop_zero: assert property (p_snoop_zero) // RULE11
    else $error("No snoop bit read nonzero");

  property p_mrrs_fixed;
    !o_avs_waitrequest |-> o_avs_readdata[CTL_MRRS_MSB:CTL_MRRS_LSB] == MRRS_FIXED;
  endproperty
  a_mrrs_fixed: assert property (p_mrrs_fixed) // RULE12
    else $error("Read request size not fixed");

  property p_pend_zero;
    !o_avs_waitrequest |-> o_avs_readdata[STS_TRANS_PND] == 1'b0;
  endproperty
  a_pend_zero: assert property (p_pend_zero) // RULE19
    else $error("Transactions pending read nonzero");

  property p_rsvd_zero;
    !o_avs_waitrequest |->
      o_avs_readdata[STS_RSVD_MSB:STS_RSVD_LSB] == '0 && !o_avs_readdata[CTL_RSVD];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // RULE20
    else $error("Reserved bits read nonzero");

  property p_clamp;
    wr_hit && i_avs_byteenable[BE_CTL_LO] && (mps_wr > mps_max)
      |=> o_max_payload == $past(mps_max);
  endproperty
  a_clamp: assert property (p_clamp) // RULE6
    else $error("Oversized payload code not clamped");

  property p_no_rsvd_code;
    o_max_payload <= MPS_512;
  endproperty
  a_no_rsvd_code: assert property (p_no_rsvd_code) // RULE7
    else $error("Payload field holds a reserved code");

  property p_log_always;
    i_err_detect[0] && !o_report_enable[0] |=> err_flag_reg[0] && !o_err_report[0];
  endproperty
  a_log_always: assert property (p_log_always) // RULE17
    else $error("Correctable error not logged or reported while disabled");

  property p_set_wins;
    i_err_detect[1] && w1c[1] |=> err_flag_reg[1];
  endproperty
  a_set_wins: assert property (p_set_wins) // RULE21
    else $error("Non-fatal flag lost to simultaneous clear");

  property p_w1c;
    err_flag_reg[2] && w1c[2] && !i_err_detect[2] |=> !err_flag_reg[2];
  endproperty
  a_w1c: assert property (p_w1c) // RULE15
    else $error("Fatal flag not cleared by write one");

  // One cycle only: a clear may follow in the very next cycle
  property p_sticky;
    err_flag_reg[3] && !w1c[3] |=> err_flag_reg[3];
  endproperty
  a_sticky: assert property (p_sticky) // RULE16
    else $error("Unsupported request flag dropped without clear");

  property p_aux_reset;
    $rose(i_reset_n) |-> aux_det_reg;
  endproperty
  a_aux_reset: assert property (p_aux_reset) // RULE18
    else $error("Aux power detected not one after reset");

  property p_cor_w1c;
    err_flag_reg[0] && w1c[0] && !i_err_detect[0] |=> !err_flag_reg[0];
  endproperty
  a_cor_w1c: assert property (p_cor_w1c) // RULE13
    else $error("Correctable flag not cleared by write one");

  property p_nf_set;
    i_err_detect[1] |=> err_flag_reg[1];
  endproperty
  a_nf_set: assert property (p_nf_set) // RULE14
    else $error("Non-fatal flag not set on detection");

  // Read data is captured at the wait edge, so it must match the live enables
  property p_en_readback;
    i_avs_read && hit && o_avs_waitrequest
      |=> o_avs_readdata[CTL_UR_EN:CTL_COR_EN] == o_report_enable;
  endproperty
  a_en_readback: assert property (p_en_readback) // RULE1
    else $error("Reporting enables read back wrong");

endmodule

`default_nettype wire

// [verification/test_port_device_control_status.sv]
// Self-checking testbench for the port device control and status registers
`default_nettype none

module test_port_device_control_status
  import pdcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic        i_clk               = 1'b0;
  logic        i_reset_n           = 1'b0;
  logic [7:0]  i_avs_address       = 8'h00;
  logic        i_avs_read          = 1'b0;
  logic        i_avs_write         = 1'b0;
  logic [31:0] i_avs_writedata     = 32'h0000_0000;
  logic [3:0]  i_avs_byteenable    = 4'h0;
  logic [3:0]  i_err_detect        = 4'h0;
  logic        i_payload_512_strap = 1'b1;
  logic        i_aux_power_detect  = 1'b1;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic [3:0]  o_report_enable;
  logic [3:0]  o_err_report;
  logic [2:0]  o_max_payload;
  logic        o_aux_pm_enable;
  logic [31:0] rd;
  int          fail_count          = 0;
  int          num_checks          = 0;

  always #25 i_clk = ~i_clk;

  pdcs_regs #(.P_ADDR_W(8)) u_dut (
    .i_clk               (i_clk),
    .i_reset_n           (i_reset_n),
    .i_avs_address       (i_avs_address),
    .i_avs_read          (i_avs_read),
    .i_avs_write         (i_avs_write),
    .i_avs_writedata     (i_avs_writedata),
    .i_avs_byteenable    (i_avs_byteenable),
    .o_avs_readdata      (o_avs_readdata),
    .o_avs_waitrequest   (o_avs_waitrequest),
    .i_err_detect        (i_err_detect),
    .i_payload_512_strap (i_payload_512_strap),
    .i_aux_power_detect  (i_aux_power_detect),
    .o_report_enable     (o_report_enable),
    .o_err_report        (o_err_report),
    .o_max_payload       (o_max_payload),
    .o_aux_pm_enable     (o_aux_pm_enable)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] ew(input logic [3:0] en, input logic [2:0] mps,
                                     input logic pm, input logic [3:0] fl, input logic ad);
    return {10'h000, 1'h0, ad, fl, 1'h0, 3'h0, 1'h0, pm, 2'h0, mps, 1'h0, en};
  endfunction

  // Detect pattern is raised so that it is sampled at the accepting edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, input logic [3:0] det);
    int n;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_read <= ~wr;
    i_avs_write <= wr;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge i_clk);
      if (n == 0) i_err_detect <= det;
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 16);
    if (o_avs_waitrequest !== 1'b0) begin
      fail_count++;
      stop_test();
    end else begin
      rd = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      i_err_detect <= 4'h0;
    end
  endtask

  task automatic rd_chk(input string what, input logic [31:0] exp);
    bus(1'b0, DEV_CTLSTS_ADDR, 32'h0000_0000, 4'h0, 4'h0);
    chk(what, exp, rd);
  endtask

  task automatic pulse(input int g, input logic [3:0] en);
    @(posedge i_clk);
    i_err_detect <= 4'(4'h1 << g);
    @(posedge i_clk);
    i_err_detect <= 4'h0;
    #1;
    chk("err report", {28'h0, en & 4'(4'h1 << g)}, {28'h0, o_err_report});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd_chk("reset word", ew(4'h0, MPS_RST, 1'b0, 4'h0, 1'b1));
    chk("reset outputs", 32'h0,
        {20'h0, o_err_report, o_report_enable, o_aux_pm_enable, o_max_payload});
  endtask

  task automatic t_ctrl();
    bus(1'b1, DEV_CTLSTS_ADDR, 32'hffff_ffff, 4'hf, 4'h0);
    rd_chk("all ones", ew(4'hf, MPS_512, 1'b1, 4'h0, 1'b1));
    chk("ctl outputs", {24'h0, 4'hf, 1'h1, MPS_512},
        {24'h0, o_report_enable, o_aux_pm_enable, o_max_payload});
    for (int g = 0; g < 4; g++) begin
      bus(1'b1, DEV_CTLSTS_ADDR, 32'(1 << g), 4'hf, 4'h0);
      rd_chk("one enable", ew(4'(4'h1 << g), MPS_128, 1'b0, 4'h0, 1'b1));
    end
    bus(1'b1, DEV_CTLSTS_ADDR, 32'hffff_ffff, 4'h0, 4'h0);
    rd_chk("no lanes", ew(4'h8, MPS_128, 1'b0, 4'h0, 1'b1));
  endtask

  task automatic t_payload();
    logic [2:0] mx;
    for (int s = 0; s < 2; s++) begin
      i_payload_512_strap <= s[0];
      repeat (4) @(posedge i_clk);
      mx = s[0] ? MPS_512 : MPS_256;
      for (int v = 0; v < 8; v++) begin
        bus(1'b1, DEV_CTLSTS_ADDR, 32'(v << 5), 4'hf, 4'h0);
        rd_chk("payload", ew(4'h0, (3'(v) > mx) ? mx : 3'(v), 1'b0, 4'h0, 1'b1));
      end
    end
  endtask

  task automatic t_flags();
    bus(1'b1, DEV_CTLSTS_ADDR, 32'h0000_0000, 4'hf, 4'h0);
    for (int g = 0; g < 4; g++) pulse(g, 4'h0);
    rd_chk("flags off", ew(4'h0, MPS_128, 1'b0, 4'hf, 1'b1));
    bus(1'b1, DEV_CTLSTS_ADDR, 32'h0000_000f, 4'hf, 4'h0);
    for (int g = 0; g < 4; g++) pulse(g, 4'hf);
    rd_chk("zero keeps", ew(4'hf, MPS_128, 1'b0, 4'hf, 1'b1));
    for (int g = 0; g < 4; g++) begin
      bus(1'b1, DEV_CTLSTS_ADDR, 32'h0000_000f | 32'(1 << (16 + g)), 4'hf, 4'h0);
      rd_chk("one clear", ew(4'hf, MPS_128, 1'b0, 4'(4'he << g), 1'b1));
    end
    bus(1'b1, DEV_CTLSTS_ADDR, 32'h000f_000f, 4'hf, 4'hf);
    rd_chk("clear vs set", ew(4'hf, MPS_128, 1'b0, 4'hf, 1'b1));
    bus(1'b1, DEV_CTLSTS_ADDR, 32'h000f_0000, 4'hf, 4'h0);
    rd_chk("cleared", ew(4'h0, MPS_128, 1'b0, 4'h0, 1'b1));
  endtask

  // Unmapped places must neither answer with data nor alias onto the pair
  task automatic t_unmapped();
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, i == 0 ? 8'hc4 : 8'hcc, 32'hffff_ffff, 4'hf, 4'h0);
      bus(1'b0, i == 0 ? 8'hc4 : 8'hcc, 32'h0000_0000, 4'h0, 4'h0);
      chk("unmapped read", UNMAPPED_DATA, rd);
      rd_chk("unmapped write", ew(4'h0, MPS_128, 1'b0, 4'h0, 1'b1));
    end
  endtask

  task automatic t_aux();
    i_aux_power_detect <= 1'b0;
    repeat (4) @(posedge i_clk);
    bus(1'b1, DEV_CTLSTS_ADDR, 32'h0010_0000, 4'hf, 4'h0);
    rd_chk("aux low", ew(4'h0, MPS_128, 1'b0, 4'h0, 1'b0));
    i_aux_power_detect <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd_chk("aux high", ew(4'h0, MPS_128, 1'b0, 4'h0, 1'b1));
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_reset();
    t_ctrl();
    t_payload();
    t_flags();
    t_unmapped();
    t_aux();
    bus(1'b1, DEV_CTLSTS_ADDR, 32'hffff_ffff, 4'hf, 4'h0);
    pulse(0, 4'hf);
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_reset();
    stop_test();
  end

endmodule

`default_nettype wire
